// ==== rtl/tcc_pkg.sv ====
// Constants and carrier types for the two-channel capture/compare timer.
// Assumes one 200 MHz core clock and plain control ports, no register bus.
package tcc_pkg;

  localparam int CNT_W = 16;
  localparam int BYTE_W = 8;
  localparam int PRE_W = 6;
  localparam int NUM_CH = 2;

  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] LIMIT_RST = 16'hffff;
  localparam logic [CNT_W-1:0] VAL_RST = 16'h0000;
  localparam logic [BYTE_W-1:0] HOLD_RST = 8'h00;
  localparam logic [PRE_W-1:0] PRE_RST = 6'h00;
  localparam logic [PRE_W-1:0] PRE_ONE = 6'h01;
  localparam logic [PRE_W:0] TAP_ONE = 7'h01;

  // Divider select code for the external count clock pin
  localparam logic [2:0] SEL_EXT = 3'h7;

  // Position of the overflow flag in the status write data
  localparam int OVF_FLAG_BIT = 7;

  // Channel mode code bits
  localparam logic [1:0] MODE_CAPTURE = 2'h0;
  localparam int MODE_BUF_BIT = 1;

  // Edge/level codes: capture edge or compare action
  localparam logic [1:0] EL_NONE = 2'h0;
  localparam logic [1:0] EL_TOGGLE = 2'h1;
  localparam logic [1:0] EL_CLEAR = 2'h2;
  localparam logic [1:0] EL_SET = 2'h3;
  localparam int EL_RISE_BIT = 0;
  localparam int EL_FALL_BIT = 1;

  typedef enum logic [2:0] {
    TGT_STATUS,
    TGT_LIMIT_HI,
    TGT_LIMIT_LO,
    TGT_CH0_HI,
    TGT_CH0_LO,
    TGT_CH1_HI,
    TGT_CH1_LO
  } tcc_wr_target_e_t;

  typedef struct packed {
    logic en;
    tcc_wr_target_e_t target;
    logic [BYTE_W-1:0] data;
  } tcc_wr_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] edge_level;
    logic toggle_on_wrap;
    logic full_duty;
    logic irq_en;
  } tcc_chan_cfg_t;

endpackage

// ==== rtl/tcc_timer_unit.sv ====
// Two-channel capture/compare timer with prescaler, modulo counter and
// buffered PWM. Assumes software drives the write port and config ports
// on core_clk_i; channel and external clock pins are asynchronous.
`timescale 1ns/1ps

module tcc_timer_unit (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Counter control
  input wire logic stop_i,
  input wire logic counter_clear_i,
  input wire logic [2:0] clock_divider_select_i,
  input wire logic ovf_irq_en_i,
  // Register writes and status read
  input wire tcc_pkg::tcc_wr_t reg_wr_i,
  input wire logic status_rd_i,
  // Channel configuration and flag clears
  input wire tcc_pkg::tcc_chan_cfg_t [1:0] chan_cfg_i,
  input wire logic [1:0] ch_flag_clr_i,
  // Pins
  input wire logic external_count_clock_pin_i,
  input wire logic [1:0] channel_pin_i,
  output logic [1:0] channel_pin_o,
  output logic [1:0] channel_pin_oe_o,
  // Register contents and status
  output logic [15:0] counter_value_pair_o,
  output logic [15:0] counter_limit_pair_o,
  output logic [1:0][15:0] channel_value_pair_o,
  output logic overflow_flag_o,
  output logic [1:0] ch_flag_o,
  output logic active_buffer_o,
  // Interrupt requests
  output logic ovf_irq_o,
  output logic [1:0] ch_irq_o
);
  import tcc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Write decode

  logic [BYTE_W-1:0] hold_q;
  logic [BYTE_W-1:0] hold_d;
  wire wr_status = reg_wr_i.en && (reg_wr_i.target == TGT_STATUS);
  wire wr_lim_hi = reg_wr_i.en && (reg_wr_i.target == TGT_LIMIT_HI);
  wire wr_lim_lo = reg_wr_i.en && (reg_wr_i.target == TGT_LIMIT_LO);
  wire any_hi = wr_lim_hi || (reg_wr_i.en && (reg_wr_i.target == TGT_CH0_HI))
    || (reg_wr_i.en && (reg_wr_i.target == TGT_CH1_HI));
  // High byte is held until the low byte lands, so a 16-bit value updates whole
  assign hold_d = any_hi ? reg_wr_i.data : hold_q;
  wire [CNT_W-1:0] wr_word = {hold_q, reg_wr_i.data};

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and count clock selection

  logic [PRE_W-1:0] pre_q;
  logic [PRE_W-1:0] pre_d;
  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_prev_q;
  wire use_ext = (clock_divider_select_i == SEL_EXT);
  wire [PRE_W:0] tap_full = TAP_ONE << clock_divider_select_i;
  wire [PRE_W-1:0] tap_mask = PRE_W'(tap_full - TAP_ONE);
  wire pre_tap = ((pre_q & tap_mask) == tap_mask);
  wire ext_edge = ext_s2_q && !ext_prev_q;
  wire run = !stop_i && !counter_clear_i;
  wire tick = run && (use_ext ? ext_edge : pre_tap);
  assign pre_d = counter_clear_i ? PRE_RST : (stop_i ? pre_q : PRE_W'(pre_q + PRE_ONE));

  ////////////////////////////////////////////////////////////////////////////
  // Counter and limit

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] limit_q;
  logic [CNT_W-1:0] limit_d;
  // Limit at reset is all ones, which behaves as free-running
  wire at_limit = (cnt_q == limit_q);
  wire ovf_evt = tick && at_limit;
  wire [CNT_W-1:0] nxt_cnt = at_limit ? CNT_RST : CNT_W'(cnt_q + CNT_ONE);
  assign cnt_d = counter_clear_i ? CNT_RST : (tick ? nxt_cnt : cnt_q);
  assign limit_d = wr_lim_lo ? wr_word : limit_q;

  ////////////////////////////////////////////////////////////////////////////
  // Overflow flag with two-step clear

  logic ovf_flag_q;
  logic ovf_flag_d;
  logic ovf_arm_q;
  logic ovf_arm_d;
  logic ovf_irq_q;
  // Clear needs a read while set; an overflow in between disarms it
  wire ovf_clr = wr_status && !reg_wr_i.data[OVF_FLAG_BIT] && ovf_arm_q;
  assign ovf_flag_d = ovf_evt || (ovf_flag_q && !ovf_clr);
  assign ovf_arm_d = !ovf_evt && ovf_flag_q && !wr_status
    && (ovf_arm_q || status_rd_i);

  ////////////////////////////////////////////////////////////////////////////
  // Link control and buffer select

  logic sel_q;
  logic sel_d;
  logic pend_q;
  logic pend_d;
  wire link = chan_cfg_i[0].mode[MODE_BUF_BIT];
  wire wr_ch0_lo = reg_wr_i.en && (reg_wr_i.target == TGT_CH0_LO);
  wire wr_ch1_lo = reg_wr_i.en && (reg_wr_i.target == TGT_CH1_LO);
  // Remember which pair was written last; it takes over at the next wrap
  assign pend_d = !link ? 1'b0 : (wr_ch1_lo ? 1'b1 : (wr_ch0_lo ? 1'b0 : pend_q));
  assign sel_d = !link ? 1'b0 : (ovf_evt ? pend_q : sel_q);

  logic [1:0][CNT_W-1:0] val_w;
  logic [1:0] pin_w;
  logic [1:0] oe_w;
  logic [1:0] flag_w;
  logic [1:0] ch_irq_w;

  ////////////////////////////////////////////////////////////////////////////
  // Channels

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    logic [CNT_W-1:0] val_q;
    logic [CNT_W-1:0] val_d;
    logic inhibit_q;
    logic inhibit_d;
    logic sync1_q;
    logic sync2_q;
    logic prev_q;
    logic pin_q;
    logic pin_d;
    logic oe_q;
    logic oe_d;
    logic flag_q;
    logic flag_d;
    logic irq_q;

    tcc_chan_cfg_t cfg;
    tcc_wr_target_e_t hi_tgt;
    tcc_wr_target_e_t lo_tgt;
    assign hi_tgt = (i == 0) ? TGT_CH0_HI : TGT_CH1_HI;
    assign lo_tgt = (i == 0) ? TGT_CH0_LO : TGT_CH1_LO;
    // Linked pair runs from channel 0 config; channel 1 config is ignored
    assign cfg = chan_cfg_i[0 + i * (link ? 0 : 1)];

    wire wr_hi = reg_wr_i.en && (reg_wr_i.target == hi_tgt);
    wire wr_lo = reg_wr_i.en && (reg_wr_i.target == lo_tgt);
    wire ch_on = (i == 0) || !link;
    wire cap_mode = ch_on && (cfg.mode == MODE_CAPTURE);
    wire cmp_mode = ch_on && (cfg.mode != MODE_CAPTURE);

    // Capture edge detect compares the second sync stage with its one-cycle-old copy
    wire rise = sync2_q && !prev_q;
    wire fall = !sync2_q && prev_q;
    wire cap_evt = cap_mode && ((cfg.edge_level[EL_RISE_BIT] && rise)
      || (cfg.edge_level[EL_FALL_BIT] && fall));

    // Channel 0 compares against whichever pair is active when linked
    wire [CNT_W-1:0] cmp_val = (i == 0 && link) ? val_w[sel_q] : val_q;
    wire cmp_hit = tick && (nxt_cnt == cmp_val) && !inhibit_q;
    wire match = cmp_mode && cmp_hit;
    wire wrap_tgl = cmp_mode && ovf_evt && cfg.toggle_on_wrap;

    // Compare waits while only the high byte is written
    assign inhibit_d = wr_hi ? 1'b1 : (wr_lo ? 1'b0 : inhibit_q);
    // A software write beats a capture landing in the same cycle
    assign val_d = wr_lo ? wr_word : (cap_evt ? cnt_q : val_q);

    logic pin_cmp;
    always_comb begin
      pin_cmp = wrap_tgl ? !pin_q : pin_q;
      if (match) begin
        unique case (cfg.edge_level)
          EL_TOGGLE: pin_cmp = !pin_q;
          EL_CLEAR: pin_cmp = 1'b0;
          EL_SET: pin_cmp = 1'b1;
          EL_NONE: pin_cmp = pin_cmp;
        endcase
      end
    end
    // Full duty with toggle on wrap also set pins the output at the pulse level of the chosen polarity
    assign pin_d = (cmp_mode && cfg.full_duty && cfg.toggle_on_wrap)
      ? !cfg.edge_level[EL_RISE_BIT] : pin_cmp;
    assign oe_d = cmp_mode && (cfg.edge_level != EL_NONE);

    // Set wins over a clear in the same cycle
    assign flag_d = cap_evt || match || (flag_q && !ch_flag_clr_i[i]);

    always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
        val_q <= VAL_RST;
        inhibit_q <= 1'b0;
        sync1_q <= 1'b0;
        sync2_q <= 1'b0;
        prev_q <= 1'b0;
        pin_q <= 1'b0;
        oe_q <= 1'b0;
        flag_q <= 1'b0;
        irq_q <= 1'b0;
      end else begin
        val_q <= val_d;
        inhibit_q <= inhibit_d;
        sync1_q <= channel_pin_i[i];
        sync2_q <= sync1_q;
        prev_q <= sync2_q;
        pin_q <= pin_d;
        oe_q <= oe_d;
        flag_q <= flag_d;
        irq_q <= flag_d && cfg.irq_en;
      end
    end

    assign val_w[i] = val_q;
    assign pin_w[i] = pin_q;
    assign oe_w[i] = oe_q;
    assign flag_w[i] = flag_q;
    assign ch_irq_w[i] = irq_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared registers

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_q <= HOLD_RST;
      pre_q <= PRE_RST;
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_prev_q <= 1'b0;
      cnt_q <= CNT_RST;
      limit_q <= LIMIT_RST;
      ovf_flag_q <= 1'b0;
      ovf_arm_q <= 1'b0;
      ovf_irq_q <= 1'b0;
      sel_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      hold_q <= hold_d;
      pre_q <= pre_d;
      ext_s1_q <= external_count_clock_pin_i;
      ext_s2_q <= ext_s1_q;
      ext_prev_q <= ext_s2_q;
      cnt_q <= cnt_d;
      limit_q <= limit_d;
      ovf_flag_q <= ovf_flag_d;
      ovf_arm_q <= ovf_arm_d;
      ovf_irq_q <= ovf_flag_d && ovf_irq_en_i;
      sel_q <= sel_d;
      pend_q <= pend_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flops

  // Counter is a plain flop view, so reading has no side effect
  assign counter_value_pair_o = cnt_q;
  assign counter_limit_pair_o = limit_q;
  assign channel_value_pair_o = val_w;
  assign overflow_flag_o = ovf_flag_q;
  assign ch_flag_o = flag_w;
  assign active_buffer_o = sel_q;
  assign ovf_irq_o = ovf_irq_q;
  assign ch_irq_o = ch_irq_w;
  assign channel_pin_o = pin_w;
  assign channel_pin_oe_o = oe_w;

endmodule // tcc_timer_unit

// ==== tb/tcc_pin_src.sv ====
// Pin-side model: channel input levels and the external count clock.
// Assumes the bench sets lvl_i and run_i just after rising edges.
`timescale 1ns/1ps
module tcc_pin_src (
  // Clock and control
  input wire logic core_clk_i,
  input wire logic [1:0] lvl_i,
  input wire logic run_i,
  // Pins
  output logic [1:0] pin_o,
  output logic ext_clk_o
);
  logic [2:0] div_q = 3'h0;
  assign pin_o = lvl_i;
  // Count clock stands still unless run, period eight core clocks
  always_ff @(posedge core_clk_i) begin
    if (run_i) begin
      div_q <= div_q + 3'h1;
    end
  end
  assign ext_clk_o = div_q[2];
endmodule // tcc_pin_src

// ==== tb/tcc_timer_unit_props.sv ====
// Checks on counter, overflow flag, limit load and channel link.
// Assumes the timer's single core clock and active-high reset.
`timescale 1ns/1ps
module tcc_timer_unit_props
  import tcc_pkg::*;
(
  // Clock and controls
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic stop_i,
  input wire logic counter_clear_i,
  input wire logic [2:0] clock_divider_select_i,
  input wire logic ovf_irq_en_i,
  input wire tcc_pkg::tcc_wr_t reg_wr_i,
  input wire logic status_rd_i,
  input wire tcc_pkg::tcc_chan_cfg_t [1:0] chan_cfg_i,
  // Observed outputs
  input wire logic [1:0] channel_pin_oe_o,
  input wire logic [15:0] counter_value_pair_o,
  input wire logic [15:0] counter_limit_pair_o,
  input wire logic overflow_flag_o,
  input wire logic ovf_irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic run0;
  logic wrap;
  logic st0;
  assign run0 = !stop_i && !counter_clear_i && clock_divider_select_i == 3'h0;
  assign wrap = run0 && counter_value_pair_o == counter_limit_pair_o;
  assign st0 = reg_wr_i.en && reg_wr_i.target == TGT_STATUS && !reg_wr_i.data[OVF_FLAG_BIT];
  ////////////////////////////////////////////////////////////////////////////
  chk_wrap_zero: assert property (wrap |=> counter_value_pair_o == CNT_RST)
    else $error("counter missed wrap");
  chk_count_step: assert property (run0 && !wrap |=>
    counter_value_pair_o == $past(counter_value_pair_o) + CNT_ONE) else $error("count step");
  chk_stop_hold: assert property (stop_i && !counter_clear_i |=>
    $stable(counter_value_pair_o)) else $error("counter moved while stopped");
  chk_clear_zero: assert property (counter_clear_i |=> counter_value_pair_o == CNT_RST)
    else $error("clear ignored");
  chk_ovf_set: assert property (wrap |=> overflow_flag_o)
    else $error("overflow flag not set");
  chk_flag_sticky: assert property (overflow_flag_o && !st0 |=> overflow_flag_o)
    else $error("overflow flag dropped");
  chk_flag_clear: assert property (status_rd_i && overflow_flag_o && stop_i ##1
    st0 && stop_i |=> !overflow_flag_o) else $error("flag clear failed");
  chk_limit_load: assert property (reg_wr_i.en && reg_wr_i.target == TGT_LIMIT_LO &&
    $past(reg_wr_i.en && reg_wr_i.target == TGT_LIMIT_HI) |=> counter_limit_pair_o ==
    {$past(reg_wr_i.data, 2), $past(reg_wr_i.data)}) else $error("limit load wrong");
  chk_ovf_irq: assert property ($rose(overflow_flag_o) && ovf_irq_en_i &&
    $past(ovf_irq_en_i) |-> ovf_irq_o) else $error("overflow request missing");
  chk_ch1_freed: assert property (chan_cfg_i[0].mode[MODE_BUF_BIT] &&
    $past(chan_cfg_i[0].mode[MODE_BUF_BIT]) |-> !channel_pin_oe_o[1]) else $error("pin1 held");
  cov_wrap: cover property (wrap);
  cov_clear: cover property ($fell(overflow_flag_o));
  cov_irq: cover property ($rose(ovf_irq_o));
endmodule // tcc_timer_unit_props

// ==== tb/test_tcc_timer_unit.sv ====
// Self-checking bench for the two-channel capture/compare timer.
// Assumes a 200 MHz core clock and the pin model beside the timer.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
  $display("[ERR] %0t got %h expected %h", $time, (a), (b)); end end
module test_tcc_timer_unit;
  import tcc_pkg::*;
  logic clk, rst, stop, clr, irq_en, rd, run, ext, flag, ovf_irq, act;
  logic [2:0] sel;
  logic [1:0] lvl, pin_i, clr_ch, pin, oe, chf, chirq;
  logic [15:0] cnt, lim;
  logic [1:0][15:0] chv;
  tcc_wr_t wr;
  tcc_chan_cfg_t [1:0] cfg;
  int mismatches = 0;
  int checks_done = 0;
  tcc_timer_unit DUT (.core_clk_i(clk), .rst_i(rst), .stop_i(stop), .counter_clear_i(clr),
    .clock_divider_select_i(sel), .ovf_irq_en_i(irq_en), .reg_wr_i(wr), .status_rd_i(rd),
    .chan_cfg_i(cfg), .ch_flag_clr_i(clr_ch), .external_count_clock_pin_i(ext),
    .channel_pin_i(pin_i), .channel_pin_o(pin), .channel_pin_oe_o(oe),
    .counter_value_pair_o(cnt), .counter_limit_pair_o(lim), .channel_value_pair_o(chv),
    .overflow_flag_o(flag), .ch_flag_o(chf), .active_buffer_o(act), .ovf_irq_o(ovf_irq),
    .ch_irq_o(chirq));
  tcc_pin_src SRC (.core_clk_i(clk), .lvl_i(lvl), .run_i(run), .pin_o(pin_i), .ext_clk_o(ext));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(); @(posedge clk); endtask
  task automatic look(int n); repeat (n) @(posedge clk); #1; endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr8(tcc_wr_target_e_t t, logic [7:0] d);
    wr <= '{1'b1, t, d};
    tick();
    wr <= '0;
  endtask
  // HI then LO back to back; leaves the write port idle
  task automatic wr16(tcc_wr_target_e_t t, logic [15:0] v);
    wr <= '{1'b1, t, v[15:8]};
    tick();
    wr <= '{1'b1, tcc_wr_target_e_t'(t + 3'h1), v[7:0]};
    tick();
    wr <= '0;
  endtask
  task automatic wait_for(logic [15:0] v, output int n);
    n = 0;
    do begin
      look(1);
      n++;
    end while (cnt !== v && n < 70000);
    if (cnt !== v) begin
      mismatches++;
      final_report();
    end
  endtask
  task automatic hi_count(output int h);
    h = 0;
    repeat (256) begin
      look(1);
      h += int'(pin[0] === 1'b1);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    look(0);
    `CHK({lim, cnt, flag, oe}, {16'hffff, 16'h0000, 3'h0})
    $display("reset done");
  endtask
  task automatic t_modulo();
    int n;
    tick();
    clr <= 1'b1;
    tick();
    clr <= 1'b0;
    wr16(TGT_LIMIT_HI, 16'h0004);
    stop <= 1'b0;
    wait_for(16'h0004, n);
    look(1);
    `CHK({cnt, flag, ovf_irq}, {16'h0000, 2'h3})
    look(1);
    `CHK(cnt, 16'h0001)
    $display("modulo done");
  endtask
  task automatic t_flag();
    int n;
    tick();
    stop <= 1'b1;
    tick();
    wr8(TGT_STATUS, 8'h00);
    tick();
    wr8(TGT_STATUS, 8'h80);
    look(0);
    `CHK(flag, 1'b1)
    tick();
    rd <= 1'b1;
    tick();
    rd <= 1'b0;
    wr8(TGT_STATUS, 8'h00);
    look(0);
    `CHK({flag, ovf_irq}, 2'h0)
    tick();
    stop <= 1'b0;
    wait_for(16'h0004, n);
    tick();
    rd <= 1'b1;
    tick();
    rd <= 1'b0;
    wait_for(16'h0004, n);
    tick();
    wr8(TGT_STATUS, 8'h00);
    look(0);
    `CHK(flag, 1'b1)
    $display("flag done");
  endtask
  task automatic t_presc();
    int n;
    logic [15:0] c;
    logic [2:0] s [2] = '{3'h2, 3'h7};
    int e [2] = '{4, 8};
    for (int i = 0; i < 2; i++) begin
      tick();
      {stop, clr, run} <= 3'h7;
      sel <= s[i];
      tick();
      {stop, clr} <= 2'h0;
      wait_for(16'h0001, n);
      wait_for(16'h0002, n);
      `CHK(n, e[i])
    end
    tick();
    run <= 1'b0;
    look(16);
    c = cnt;
    look(16);
    `CHK(cnt, c)
    $display("prescale done");
  endtask
  task automatic t_pwm();
    int n;
    int h;
    logic [1:0] m [3] = '{2'h2, 2'h0, 2'h3};
    int e [3] = '{128, 0, 256};
    tick();
    sel <= 3'h0;
    wr16(TGT_LIMIT_HI, 16'h00ff);
    tick();
    wr16(TGT_CH0_HI, 16'h0080);
    for (int i = 0; i < 3; i++) begin
      tick();
      cfg[0] <= '{2'h1, EL_CLEAR, m[i][1], m[i][0], 1'b1};
      wait_for(16'h00ff, n);
      wait_for(16'h00ff, n);
      `CHK(n, 256)
      hi_count(h);
      `CHK(h, e[i])
    end
    `CHK({oe[0], chf[0], chirq[0]}, 3'h7)
    tick();
    cfg[0] <= '{2'h1, EL_CLEAR, 1'b1, 1'b0, 1'b1};
    wait_for(16'h0080, n);
    tick();
    wr16(TGT_CH0_HI, 16'h0040);
    wait_for(16'h00ff, n);
    hi_count(h);
    `CHK(h, 64)
    tick();
    wr16(TGT_CH0_HI, 16'h0080);
    wait_for(16'h00ff, n);
    hi_count(h);
    `CHK(h, 128)
    $display("pwm done");
  endtask
  task automatic t_capture();
    logic [15:0] c;
    // Stop off zero so a missed capture cannot match the reset value
    repeat (4) tick();
    stop <= 1'b1;
    cfg[1] <= '{MODE_CAPTURE, 2'h1, 1'b0, 1'b0, 1'b1};
    look(2);
    c = cnt;
    tick();
    lvl <= 2'h2;
    look(6);
    `CHK(chv[1], c)
    `CHK({chf[1], chirq[1], oe[1]}, 3'h6)
    tick();
    clr_ch <= 2'h2;
    tick();
    clr_ch <= 2'h0;
    look(0);
    `CHK({chf[1], chirq[1]}, 2'h0)
    tick();
    cfg[1].edge_level <= 2'h2;
    stop <= 1'b0;
    tick();
    stop <= 1'b1;
    lvl <= 2'h0;
    look(6);
    `CHK({chv[1], chf[1]}, {c + 16'h0001, 1'b1})
    $display("capture done");
  endtask
  task automatic t_link();
    int n;
    int h;
    tick();
    cfg[1] <= '{2'h1, EL_SET, 1'b1, 1'b0, 1'b0};
    cfg[0] <= '{2'h2, EL_SET, 1'b1, 1'b0, 1'b1};
    wr16(TGT_CH0_HI, 16'h0040);
    tick();
    wr16(TGT_CH1_HI, 16'h0008);
    look(0);
    `CHK({act, oe[1]}, 2'h0)
    `CHK(chv, {16'h0008, 16'h0040})
    tick();
    stop <= 1'b0;
    wait_for(16'h00ff, n);
    hi_count(h);
    `CHK({act, h[8:0]}, {1'b1, 9'h0f8})
    tick();
    wr16(TGT_CH0_HI, 16'h0040);
    wait_for(16'h00ff, n);
    hi_count(h);
    `CHK({act, h[8:0]}, {1'b0, 9'h0c0})
    tick();
    cfg[0] <= '{2'h1, EL_TOGGLE, 1'b0, 1'b0, 1'b0};
    wait_for(16'h0080, n);
    h = int'(pin[0]);
    look(256);
    `CHK(pin[0], ~h[0])
    $display("link done");
  endtask
  initial begin
    {rst, stop, irq_en} <= 3'h7;
    {clr, rd, run} <= 3'h0;
    sel <= 3'h0;
    lvl <= 2'h0;
    clr_ch <= 2'h0;
    wr <= '0;
    cfg <= '0;
    repeat (8) tick();
    rst <= 1'b0;
    tick();
    t_reset();
    t_modulo();
    t_flag();
    t_presc();
    t_pwm();
    t_capture();
    t_link();
    final_report();
  end
endmodule // test_tcc_timer_unit
bind tcc_timer_unit tcc_timer_unit_props PROPS (.core_clk_i, .rst_i, .stop_i,
  .counter_clear_i, .clock_divider_select_i, .ovf_irq_en_i, .reg_wr_i, .status_rd_i,
  .chan_cfg_i, .channel_pin_oe_o, .counter_value_pair_o, .counter_limit_pair_o,
  .overflow_flag_o, .ovf_irq_o);
